// [hdl/usbtc_pkg.sv]
// Functional notes
// - device pull-up needs module on and power
// - override set: pull-up follows its control bit
// - low session voltage drops pull-up automatically
// - host select engages both D+/D- pull-downs
// - override set: pull-downs follow bits 5, 4
// - token direction depends on device or host
// - full speed, or low speed in host only
// - 16 endpoints, 32 directions, all types
// - up to sixteen transfers queued without servicing
// - software role switch, shared paths both roles
package usbtc_pkg;

  // register byte offsets
  localparam logic [7:0] USB_CTRL_OFS = 8'h00;
  localparam logic [7:0] OTG_CTRL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] EP_ENABLE_OFS = 8'h0C;
  localparam logic [7:0] XFER_ARM_OFS = 8'h10;

  // usb_control_reg fields
  localparam int MODULE_ON_POS = 0;
  localparam int MODULE_POWER_POS = 1;
  localparam int HOST_ROLE_POS = 3;
  localparam int LOW_SPEED_POS = 4;
  localparam logic [31:0] USB_CTRL_MASK = 32'h0000_001B;

  // otg_control_reg fields
  localparam int OVERRIDE_POS = 2;
  localparam int DM_PULLDOWN_POS = 4;
  localparam int DP_PULLDOWN_POS = 5;
  localparam int DP_PULLUP_POS = 7;
  localparam logic [31:0] OTG_CTRL_MASK = 32'h0000_00B4;

  // status fields
  localparam int ST_SESSION_POS = 0;
  localparam int ST_PULLUP_POS = 1;
  localparam int ST_DP_PD_POS = 2;
  localparam int ST_DM_PD_POS = 3;
  localparam int ST_LOW_SPEED_POS = 4;
  localparam int ST_HOST_POS = 5;
  localparam int ST_FULL_POS = 6;
  localparam int ST_REFUSED_POS = 7;
  localparam int ST_COUNT_LSB = 8;
  localparam int ST_HEAD_VALID_POS = 13;

  // transfer arm fields
  localparam int ARM_EP_LSB = 0;
  localparam int ARM_RX_POS = 4;

  // reset values
  localparam logic [31:0] USB_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] OTG_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] EP_ENABLE_RST = 32'h0000_0000;

  // endpoint and queue sizes
  localparam int EP_NUM = 16;
  localparam int EP_W = 4;
  localparam int QUEUE_DEPTH = 16;
  localparam int QUEUE_AW = 4;
  localparam int QUEUE_CW = 5;

  // bus speeds in bits per second
  localparam int FULL_SPEED_BPS = 12000000;
  localparam int LOW_SPEED_BPS = 1500000;

  // token identifiers from the serial interface engine
  typedef enum logic [1:0]
  {
    USBTC_TOK_OUT = 2'h0,
    USBTC_TOK_IN = 2'h1,
    USBTC_TOK_SETUP = 2'h2
  } usbtc_pid_t;

endpackage : usbtc_pkg

// [hdl/usbtc_xfer_queue.sv]
`timescale 1ns/1ps
// ring of pending endpoint transfers, served in arm order
module usbtc_xfer_queue
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic push,
  input wire logic [usbtc_pkg::EP_W-1:0] push_ep,
  input wire logic push_rx,
  input wire logic pop,
  output logic [usbtc_pkg::EP_W-1:0] head_ep,
  output logic head_rx,
  output logic head_valid,
  output logic full,
  output logic [usbtc_pkg::QUEUE_CW-1:0] count
);

  logic [usbtc_pkg::EP_W:0] mem_reg [usbtc_pkg::QUEUE_DEPTH];
  logic [usbtc_pkg::QUEUE_AW-1:0] wr_reg;
  logic [usbtc_pkg::QUEUE_AW-1:0] wr_next;
  logic [usbtc_pkg::QUEUE_AW-1:0] rd_reg;
  logic [usbtc_pkg::QUEUE_AW-1:0] rd_next;
  logic [usbtc_pkg::QUEUE_CW-1:0] cnt_reg;
  logic [usbtc_pkg::QUEUE_CW-1:0] cnt_next;
  logic do_push;
  logic do_pop;

  // a push into a full ring is dropped; pop of an empty one too
  always_comb
  begin
    do_push = push && !full;
    do_pop = pop && head_valid;
    wr_next = do_push ? wr_reg + 1'b1 : wr_reg;
    rd_next = do_pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg;
    if (do_push && !do_pop)
    begin
      cnt_next = cnt_reg + 1'b1;
    end
    else if (do_pop && !do_push)
    begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // pointers and fill level
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else if (ce)
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage needs no reset, entries are guarded by the count
  always_ff @(posedge core_clk)
  begin
    if (ce && do_push)
    begin
      mem_reg[wr_reg] <= {push_rx, push_ep};
    end
  end

  // sixteen pending transfers fit without software help
  assign full = (cnt_reg == usbtc_pkg::QUEUE_CW'(usbtc_pkg::QUEUE_DEPTH));
  assign head_valid = (cnt_reg != '0);
  assign count = cnt_reg;
  assign head_ep = mem_reg[rd_reg][usbtc_pkg::EP_W-1:0];
  assign head_rx = mem_reg[rd_reg][usbtc_pkg::EP_W];

endmodule : usbtc_xfer_queue

// [hdl/usbtc_term_ctrl.sv]
`timescale 1ns/1ps
// termination, role, speed and transfer queue control behind wishbone
module usbtc_term_ctrl
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic vbus_session_valid,
  input wire logic tok_valid,
  input wire logic [1:0] tok_pid,
  input wire logic eng_xfer_done,
  output logic dplus_pullup_en,
  output logic dplus_pulldown_en,
  output logic dminus_pulldown_en,
  output logic host_mode,
  output logic low_speed_en,
  output logic tok_is_rx,
  output logic tok_is_tx,
  output logic xfer_valid,
  output logic [3:0] xfer_ep,
  output logic xfer_is_rx
);

  // byte-lane merge for a software write
  function automatic logic [31:0] lane_merge
  (
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  logic [31:0] usb_control_reg;
  logic [31:0] usb_control_next;
  logic [31:0] otg_control_reg;
  logic [31:0] otg_control_next;
  logic [31:0] ep_enable_reg;
  logic [31:0] ep_enable_next;
  logic refused_reg;
  logic refused_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic vbus_s1_reg;
  logic vbus_s2_reg;
  logic vbus_s3_reg;
  logic session_reg;
  logic session_next;
  logic pullup_reg;
  logic pullup_next;
  logic dp_pd_reg;
  logic dp_pd_next;
  logic dm_pd_reg;
  logic dm_pd_next;
  logic host_reg;
  logic host_next;
  logic ls_reg;
  logic ls_next;
  logic tok_rx_reg;
  logic tok_rx_next;
  logic tok_tx_reg;
  logic tok_tx_next;
  logic head_valid_reg;
  logic [3:0] head_ep_reg;
  logic head_rx_reg;
  logic req;
  logic wr_hit;
  logic arm_push;
  logic [3:0] arm_ep;
  logic arm_rx;
  logic arm_allowed;
  logic q_pop;
  logic [3:0] q_head_ep;
  logic q_head_rx;
  logic q_head_valid;
  logic q_full;
  logic [4:0] q_count;
  logic [31:0] status_word;
  logic override;

  // one access per cycle; ack drops the cycle after it rose
  always_comb
  begin
    req = wb_cyc_i && wb_stb_i && !ack_reg;
    wr_hit = req && wb_we_i;
    ack_next = req;
    arm_ep = wb_dat_i[usbtc_pkg::ARM_EP_LSB +: 4];
    arm_rx = wb_dat_i[usbtc_pkg::ARM_RX_POS];
    // rx directions sit in the low half, tx in the high half
    arm_allowed = ep_enable_reg[{!arm_rx, arm_ep}];
    arm_push = wr_hit && wb_sel_i[0]
      && (wb_adr_i == usbtc_pkg::XFER_ARM_OFS) && arm_allowed;
  end

  // status view of the live termination and queue state
  always_comb
  begin
    status_word = '0;
    status_word[usbtc_pkg::ST_SESSION_POS] = session_reg;
    status_word[usbtc_pkg::ST_PULLUP_POS] = pullup_reg;
    status_word[usbtc_pkg::ST_DP_PD_POS] = dp_pd_reg;
    status_word[usbtc_pkg::ST_DM_PD_POS] = dm_pd_reg;
    status_word[usbtc_pkg::ST_LOW_SPEED_POS] = ls_reg;
    status_word[usbtc_pkg::ST_HOST_POS] = host_reg;
    status_word[usbtc_pkg::ST_FULL_POS] = q_full;
    status_word[usbtc_pkg::ST_REFUSED_POS] = refused_reg;
    status_word[usbtc_pkg::ST_COUNT_LSB +: 5] = q_count;
    status_word[usbtc_pkg::ST_HEAD_VALID_POS] = q_head_valid;
  end

  // register writes, read mux and sticky refusal flag
  always_comb
  begin
    usb_control_next = usb_control_reg;
    otg_control_next = otg_control_reg;
    ep_enable_next = ep_enable_reg;
    refused_next = refused_reg;
    rdata_next = '0;
    if (wr_hit)
    begin
      unique case (wb_adr_i)
        usbtc_pkg::USB_CTRL_OFS:
        begin
          // role switch is plain software control
          usb_control_next = lane_merge(usb_control_reg, wb_dat_i,
            wb_sel_i) & usbtc_pkg::USB_CTRL_MASK;
        end
        usbtc_pkg::OTG_CTRL_OFS:
        begin
          otg_control_next = lane_merge(otg_control_reg, wb_dat_i,
            wb_sel_i) & usbtc_pkg::OTG_CTRL_MASK;
        end
        usbtc_pkg::EP_ENABLE_OFS:
        begin
          ep_enable_next = lane_merge(ep_enable_reg, wb_dat_i, wb_sel_i);
        end
        usbtc_pkg::STATUS_OFS:
        begin
          if (wb_sel_i[0] && wb_dat_i[usbtc_pkg::ST_REFUSED_POS])
          begin
            refused_next = 1'b0;
          end
        end
        default:
        begin
          // unmapped offsets are acked and dropped
        end
      endcase
    end
    else if (req)
    begin
      unique case (wb_adr_i)
        usbtc_pkg::USB_CTRL_OFS: rdata_next = usb_control_reg;
        usbtc_pkg::OTG_CTRL_OFS: rdata_next = otg_control_reg;
        usbtc_pkg::STATUS_OFS: rdata_next = status_word;
        usbtc_pkg::EP_ENABLE_OFS: rdata_next = ep_enable_reg;
        default: rdata_next = '0;
      endcase
    end
    // refusal on full or disabled endpoint beats a same-cycle clear
    if (wr_hit && wb_sel_i[0] && (wb_adr_i == usbtc_pkg::XFER_ARM_OFS)
      && (!arm_allowed || q_full))
    begin
      refused_next = 1'b1;
    end
  end

  // bus-facing registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      usb_control_reg <= usbtc_pkg::USB_CTRL_RST;
      otg_control_reg <= usbtc_pkg::OTG_CTRL_RST;
      ep_enable_reg <= usbtc_pkg::EP_ENABLE_RST;
      refused_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else if (ce)
    begin
      usb_control_reg <= usb_control_next;
      otg_control_reg <= otg_control_next;
      ep_enable_reg <= ep_enable_next;
      refused_reg <= refused_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // comparator pin synchroniser; stage one feeds stage two only
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      vbus_s1_reg <= 1'b0;
      vbus_s2_reg <= 1'b0;
      vbus_s3_reg <= 1'b0;
    end
    else if (ce)
    begin
      vbus_s1_reg <= vbus_session_valid;
      vbus_s2_reg <= vbus_s1_reg;
      vbus_s3_reg <= vbus_s2_reg;
    end
  end

  // termination decode, registered so the pins never glitch
  always_comb
  begin
    override = otg_control_reg[usbtc_pkg::OVERRIDE_POS];
    session_next = (vbus_s2_reg == vbus_s3_reg) ? vbus_s2_reg : session_reg;
    host_next = usb_control_reg[usbtc_pkg::HOST_ROLE_POS];
    // low speed only honoured while acting as host
    ls_next = usb_control_reg[usbtc_pkg::LOW_SPEED_POS] && host_next;
    if (override)
    begin
      pullup_next = otg_control_reg[usbtc_pkg::DP_PULLUP_POS];
      dp_pd_next = otg_control_reg[usbtc_pkg::DP_PULLDOWN_POS];
      dm_pd_next = otg_control_reg[usbtc_pkg::DM_PULLDOWN_POS];
    end
    else
    begin
      // individual bits have no say without the override
      pullup_next = usb_control_reg[usbtc_pkg::MODULE_ON_POS]
        && usb_control_reg[usbtc_pkg::MODULE_POWER_POS]
        && !host_next;
      dp_pd_next = host_next;
      dm_pd_next = host_next;
    end
    // back-drive guard needs no firmware; hardware drops the pull-up
    if (!session_next)
    begin
      pullup_next = 1'b0;
    end
  end

  // token direction, in the controller's own rx/tx terms
  always_comb
  begin
    tok_rx_next = 1'b0;
    tok_tx_next = 1'b0;
    if (tok_valid)
    begin
      if (host_reg)
      begin
        tok_rx_next = (tok_pid == usbtc_pkg::USBTC_TOK_IN);
        tok_tx_next = (tok_pid == usbtc_pkg::USBTC_TOK_OUT)
          || (tok_pid == usbtc_pkg::USBTC_TOK_SETUP);
      end
      else
      begin
        tok_rx_next = (tok_pid == usbtc_pkg::USBTC_TOK_OUT)
          || (tok_pid == usbtc_pkg::USBTC_TOK_SETUP);
        tok_tx_next = (tok_pid == usbtc_pkg::USBTC_TOK_IN);
      end
    end
  end

  // line-facing state
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      session_reg <= 1'b0;
      pullup_reg <= 1'b0;
      dp_pd_reg <= 1'b0;
      dm_pd_reg <= 1'b0;
      host_reg <= 1'b0;
      ls_reg <= 1'b0;
      tok_rx_reg <= 1'b0;
      tok_tx_reg <= 1'b0;
      head_valid_reg <= 1'b0;
      head_ep_reg <= '0;
      head_rx_reg <= 1'b0;
    end
    else if (ce)
    begin
      session_reg <= session_next;
      pullup_reg <= pullup_next;
      dp_pd_reg <= dp_pd_next;
      dm_pd_reg <= dm_pd_next;
      host_reg <= host_next;
      ls_reg <= ls_next;
      tok_rx_reg <= tok_rx_next;
      tok_tx_reg <= tok_tx_next;
      head_valid_reg <= q_head_valid && !q_pop;
      // empty ring shows zero, never unwritten storage
      head_ep_reg <= q_head_valid ? q_head_ep : '0;
      head_rx_reg <= q_head_valid && q_head_rx;
    end
  end

  // the engine retires the head; one queue serves both roles
  assign q_pop = eng_xfer_done && head_valid_reg;

  usbtc_xfer_queue u_queue
  (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .push(arm_push),
    .push_ep(arm_ep),
    .push_rx(arm_rx),
    .pop(q_pop),
    .head_ep(q_head_ep),
    .head_rx(q_head_rx),
    .head_valid(q_head_valid),
    .full(q_full),
    .count(q_count)
  );

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign dplus_pullup_en = pullup_reg;
  assign dplus_pulldown_en = dp_pd_reg;
  assign dminus_pulldown_en = dm_pd_reg;
  assign host_mode = host_reg;
  assign low_speed_en = ls_reg;
  assign tok_is_rx = tok_rx_reg;
  assign tok_is_tx = tok_tx_reg;
  assign xfer_valid = head_valid_reg;
  assign xfer_ep = head_ep_reg;
  assign xfer_is_rx = head_rx_reg;

endmodule : usbtc_term_ctrl

// [tb/usbtc_term_ctrl_assertions.sv]
`timescale 1ns/1ps
// port-level checks; shadows the control writes to predict the outputs
module usbtc_term_ctrl_assertions
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic vbus_session_valid,
  input wire logic tok_valid,
  input wire logic [1:0] tok_pid,
  input wire logic eng_xfer_done,
  input wire logic dplus_pullup_en,
  input wire logic dplus_pulldown_en,
  input wire logic dminus_pulldown_en,
  input wire logic host_mode,
  input wire logic low_speed_en,
  input wire logic tok_is_rx,
  input wire logic tok_is_tx,
  input wire logic xfer_valid
);
  logic [31:0] usb_reg, usb_next, otg_reg, otg_next;
  logic wr0, pu_ctl, dp_exp, dm_exp, ls_exp, h_exp, rx_exp, tx_exp;
  // shadow registers take a write on the edge that accepts it
  always_comb
  begin
    wr0 = ce && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
    usb_next = usb_reg;
    otg_next = otg_reg;
    if (wr0 && wb_adr_i == usbtc_pkg::USB_CTRL_OFS)
      usb_next = wb_dat_i & usbtc_pkg::USB_CTRL_MASK;
    if (wr0 && wb_adr_i == usbtc_pkg::OTG_CTRL_OFS)
      otg_next = wb_dat_i & usbtc_pkg::OTG_CTRL_MASK;
  end
  always_ff @(posedge core_clk)
  begin
    usb_reg <= rst ? 32'h0000_0000 : usb_next;
    otg_reg <= rst ? 32'h0000_0000 : otg_next;
  end
  // expected levels; the session guard is applied in the properties
  assign h_exp = usb_reg[3];
  assign pu_ctl = otg_reg[2] ? otg_reg[7] : usb_reg[0] & usb_reg[1] & !h_exp;
  assign dp_exp = otg_reg[2] ? otg_reg[5] : h_exp;
  assign dm_exp = otg_reg[2] ? otg_reg[4] : h_exp;
  assign ls_exp = usb_reg[4] & h_exp;
  assign rx_exp = host_mode ? tok_pid == 2'h1 : tok_pid[0] == 1'b0;
  assign tx_exp = host_mode ? tok_pid[0] == 1'b0 : tok_pid == 2'h1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst || !ce);
  sequence s_taken; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_vbus_low; !vbus_session_valid [*6]; endsequence
  sequence s_vbus_high; vbus_session_valid [*6]; endsequence
  a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answers:
    assert property (s_taken |=> wb_ack_o) else $error("no ack");
  a_dat_idle_zero:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
  a_host_follows:
    assert property (host_mode == $past(h_exp)) else $error("role wrong");
  a_dplus_pulldown:
    assert property (dplus_pulldown_en == $past(dp_exp))
      else $error("d+ pull-down wrong");
  a_dminus_pulldown:
    assert property (dminus_pulldown_en == $past(dm_exp))
      else $error("d- pull-down wrong");
  a_pullup_gated:
    assert property (s_vbus_high |-> dplus_pullup_en == $past(pu_ctl))
      else $error("pull-up wrong");
  a_pullup_session:
    assert property (s_vbus_low |-> !dplus_pullup_en)
      else $error("pull-up without session");
  a_low_speed_host:
    assert property (low_speed_en == $past(ls_exp)) else $error("speed");
  a_token_rx:
    assert property (tok_valid |=> tok_is_rx == $past(rx_exp))
      else $error("rx class wrong");
  a_token_tx:
    assert property (tok_valid |=> tok_is_tx == $past(tx_exp))
      else $error("tx class wrong");
  a_done_pops:
    assert property (eng_xfer_done && xfer_valid |=> !xfer_valid)
      else $error("head not retired");
endmodule : usbtc_term_ctrl_assertions
bind usbtc_term_ctrl usbtc_term_ctrl_assertions chk_u (.*);

// [tb/usbtc_sie_model.sv]
`timescale 1ns/1ps
// engine stand-in: token pulses on command, retires heads unless stalled
module usbtc_engine_model
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic go_tok,
  input wire logic [1:0] go_pid,
  input wire logic stall,
  input wire logic xfer_valid,
  output logic tok_valid,
  output logic [1:0] tok_pid,
  output logic eng_xfer_done
);
  logic tv_next, done_next;
  logic [1:0] pid_next;
  // pid is inverted between pulses so a stale value never looks valid
  always_comb
  begin
    tv_next = go_tok;
    pid_next = go_tok ? go_pid : ~tok_pid;
    done_next = xfer_valid && !stall && !eng_xfer_done;
  end
  always_ff @(posedge core_clk)
  begin
    tok_valid <= rst ? 1'b0 : tv_next;
    tok_pid <= rst ? 2'h0 : pid_next;
    eng_xfer_done <= rst ? 1'b0 : done_next;
  end
endmodule : usbtc_engine_model

// [tb/test_usb_otg_termination_control.sv]
`timescale 1ns/1ps
module test_usb_otg_termination_control;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, vbus = 1'b0;
  logic go_tok = 1'b0, stall = 1'b1, ack, pu, dpd, dmd, hm, ls;
  logic rx, tx, xv, xrx, tv, done;
  logic [1:0] go_pid = 2'h0, pid;
  logic [3:0] sel = 4'hf, xep;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, rd, q, u, o;
  logic [4:0] e;
  logic [4:0] expq[$];
  logic [7:0] offs[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
  int n_errors = 0;
  int comparisons = 0;
  int n;
  always #50 core_clk = ~core_clk;
  usbtc_term_ctrl dut_u (.core_clk(core_clk), .rst(rst), .ce(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .vbus_session_valid(vbus), .tok_valid(tv), .tok_pid(pid),
    .eng_xfer_done(done), .dplus_pullup_en(pu), .dplus_pulldown_en(dpd),
    .dminus_pulldown_en(dmd), .host_mode(hm), .low_speed_en(ls),
    .tok_is_rx(rx), .tok_is_tx(tx), .xfer_valid(xv), .xfer_ep(xep),
    .xfer_is_rx(xrx));
  usbtc_engine_model eng_u (.core_clk(core_clk), .rst(rst), .go_tok(go_tok),
    .go_pid(go_pid), .stall(stall), .xfer_valid(xv), .tok_valid(tv),
    .tok_pid(pid), .eng_xfer_done(done));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle; request held until ack is sampled, then one idle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      n_errors++;
      report_and_stop();
    end
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask : wb
  task automatic report_and_stop();
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // expected {pull-up, d+ pd, d- pd, host, low speed}
  function automatic logic [4:0] term_exp(input logic [31:0] uc,
    input logic [31:0] oc, input logic s);
    if (oc[2])
      return {s & oc[7], oc[5], oc[4], uc[3], uc[4] & uc[3]};
    return {s & uc[0] & uc[1] & !uc[3], {3{uc[3]}}, uc[4] & uc[3]};
  endfunction : term_exp
  // retired transfers must leave in arm order
  always @(posedge core_clk)
    if (done === 1'b1 && xv === 1'b1 && expq.size() > 0)
      check({xep, xrx}, expq.pop_front());
  // hang guard, far beyond the length of the sequence
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(32'h66ad));
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    foreach (offs[i])
    begin
      wb(1'b0, offs[i], 32'h0000_0000);
      check(q, 32'h0000_0000);
    end
    vbus <= 1'b1;
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    wb(1'b0, 8'h20, 32'h0000_0000);
    check(q, 32'h0000_0000);
    for (int i = 0; i < 40; i++)
    begin
      u = $urandom;
      o = $urandom;
      vbus <= ($urandom % 4) != 0;
      wb(1'b1, 8'h00, u);
      wb(1'b1, 8'h04, o);
      repeat (6) @(posedge core_clk);
      wb(1'b0, 8'h00, 32'h0000_0000);
      check(q, u & usbtc_pkg::USB_CTRL_MASK);
      wb(1'b0, 8'h04, 32'h0000_0000);
      check(q, o & usbtc_pkg::OTG_CTRL_MASK);
      check({pu, dpd, dmd, hm, ls}, term_exp(u, o, vbus));
    end
    // frozen enable holds the synchroniser, so the lines keep their state
    ce <= 1'b0;
    vbus <= ~vbus;
    repeat (8) @(posedge core_clk);
    check({pu, dpd, dmd, hm, ls}, term_exp(u, o, !vbus));
    ce <= 1'b1;
    repeat (6) @(posedge core_clk);
    check({pu, dpd, dmd, hm, ls}, term_exp(u, o, vbus));
    // token direction for both roles and every pid
    for (int h = 0; h < 2; h++)
    begin
      wb(1'b1, 8'h00, h ? 32'h0000_0008 : 32'h0000_0003);
      for (int p = 0; p < 4; p++)
      begin
        go_tok <= 1'b1;
        go_pid <= p[1:0];
        @(posedge core_clk);
        go_tok <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        check({rx, tx}, p == 3 ? 2'h0 : (p == 1) ^ h ? 2'h1 : 2'h2);
        @(posedge core_clk);
      end
    end
    // disabled direction refused, flag clears on write of one
    wb(1'b1, 8'h0C, 32'hFFFF_7FFF);
    wb(1'b1, 8'h10, 32'h0000_001F);
    wb(1'b0, 8'h08, 32'h0000_0000);
    check(q[7], 1'b1);
    wb(1'b1, 8'h08, 32'h0000_0080);
    wb(1'b0, 8'h08, 32'h0000_0000);
    check(q[7], 1'b0);
    // fill the queue while the engine stalls, then let it drain
    for (int i = 0; i < 17; i++)
    begin
      e = $urandom;
      e = e == 5'h1F ? 5'h0F : e;
      wb(1'b1, 8'h10, {27'h0, e});
      if (i < 16)
        expq.push_back({e[3:0], e[4]});
    end
    repeat (3) @(posedge core_clk);
    wb(1'b0, 8'h08, 32'h0000_0000);
    check(q[13:6], {1'b1, 5'h10, 2'h3});
    stall <= 1'b0;
    for (int i = 0; i < 500 && expq.size() > 0; i++)
      @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    wb(1'b0, 8'h08, 32'h0000_0000);
    check(q[13:6], 8'h02);
    report_and_stop();
  end
endmodule : test_usb_otg_termination_control
